// [hdl/hbasp_port.sv]
// Host bus address phase: address and cycle valid strobe, master and slave roles
//
// Operation
// - Drive address only as master, else input
// - Slave captures address at strobe-sampling falling edge
// - Master: address after rise, strobe after fall
// - Drive strobe only as master, else tristate
// - Drive strobe inactive before releasing it
// - Address, codes, direction from preceding rising edge
// - Sample incoming strobe on falling clock edges
// - Claim only with a select sampled low
// - Qualified inputs not needed at strobe assertion
// - Master holds strobe for whole transaction
`timescale 1ns/1ps
`include "hbasp_map.svh"

module hbasp_port
(
    input  wire logic               clk,
    input  wire logic               srst,
    // Host bus pins
    input  wire logic               host_bus_clock,
    input  wire hbasp_pkg::hbasp_addr_t addr_in,
    output hbasp_pkg::hbasp_addr_t  addr_out,
    output logic                    addr_oe_n,
    output hbasp_pkg::hbasp_tc_t    transfer_code_out,
    output hbasp_pkg::hbasp_siz_t   byte_count_code_out,
    output logic                    rw_out,
    input  wire logic               cycle_valid_strobe_n_in,
    output logic                    cycle_valid_strobe_n_out,
    output logic                    cycle_valid_strobe_oe_n,
    input  wire logic               register_select_n,
    input  wire logic               bridge_window_select_n,
    // Arbitration result from the arbiter
    input  wire logic               bus_owned,
    // Master request side
    input  wire logic               mst_req,
    input  wire hbasp_pkg::hbasp_addr_t mst_addr,
    input  wire hbasp_pkg::hbasp_tc_t   mst_tc,
    input  wire hbasp_pkg::hbasp_siz_t  mst_siz,
    input  wire logic               mst_rw,
    input  wire logic               mst_done,
    output logic                    mst_busy,
    // Slave side results
    output logic                    slv_claim,
    output logic                    slv_end,
    output logic                    slv_active,
    output hbasp_pkg::hbasp_addr_t  slv_addr,
    output hbasp_pkg::hbasp_off_t   slv_offset,
    output logic                    slv_to_regs,
    output logic                    slv_to_window
);
    import hbasp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and host clock edge detection

    logic [`HBASP_SYNC_W-1:0] sync1_q;
    logic [`HBASP_SYNC_W-1:0] sync2_q;
    logic                     hclk_d_q;
    logic                     hclk_rise;
    logic                     hclk_fall;
    logic                     strb_s;
    logic                     regsel_s;
    logic                     winsel_s;
    hbasp_addr_t              addr_s;

    // Two stages on every pin; all pins lag equally so sampling stays aligned
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_q  <= {`HBASP_SYNC_W{1'b1}};
            sync2_q  <= {`HBASP_SYNC_W{1'b1}};
            hclk_d_q <= 1'b1;
        end
        else
        begin
            sync1_q  <= {addr_in, bridge_window_select_n, register_select_n,
                         cycle_valid_strobe_n_in, host_bus_clock};
            sync2_q  <= sync1_q;
            hclk_d_q <= sync2_q[`HBASP_SYNC_CLK];
        end
    end

    // Edges seen only on the second stage
    assign hclk_rise = sync2_q[`HBASP_SYNC_CLK] & ~hclk_d_q;
    assign hclk_fall = ~sync2_q[`HBASP_SYNC_CLK] & hclk_d_q;
    assign strb_s    = sync2_q[`HBASP_SYNC_STRB];
    assign regsel_s  = sync2_q[`HBASP_SYNC_REGSEL];
    assign winsel_s  = sync2_q[`HBASP_SYNC_WINSEL];
    assign addr_s    = sync2_q[`HBASP_SYNC_ADDR_HI:`HBASP_SYNC_ADDR_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Master sequencer

    hbasp_mst_t  mst_q, mst_d;
    hbasp_addr_t addr_q, addr_d;
    hbasp_tc_t   tc_q, tc_d;
    hbasp_siz_t  siz_q, siz_d;
    logic        rw_q, rw_d;
    logic        aoe_n_q, aoe_n_d;
    logic        strb_q, strb_d;
    logic        soe_n_q, soe_n_d;
    logic        slv_idle;

    // Next state and pin drive; pin values follow the state we enter
    always_comb
    begin
        mst_d   = mst_q;
        addr_d  = addr_q;
        tc_d    = tc_q;
        siz_d   = siz_q;
        rw_d    = rw_q;
        unique case (mst_q)
            HBASP_M_IDLE:
            begin
                // Refuse a start while a foreign transaction is in progress
                if (mst_req && slv_idle)
                begin
                    mst_d  = HBASP_M_WRISE;
                    addr_d = mst_addr;
                    tc_d   = mst_tc;
                    siz_d  = mst_siz;
                    rw_d   = mst_rw;
                end
            end
            HBASP_M_WRISE:
            begin
                if (bus_owned && hclk_rise)
                    mst_d = HBASP_M_ADDR;
            end
            HBASP_M_ADDR:
            begin
                if (hclk_fall)
                    mst_d = HBASP_M_STRB;
            end
            HBASP_M_STRB:
            begin
                if (mst_done)
                    mst_d = HBASP_M_NEG;
            end
            HBASP_M_NEG:
            begin
                if (hclk_rise)
                    mst_d = HBASP_M_IDLE;
            end
        endcase
        // address driven only while owning bus
        aoe_n_d = ~(bus_owned && (mst_d == HBASP_M_ADDR || mst_d == HBASP_M_STRB
                                  || mst_d == HBASP_M_NEG));
        soe_n_d = aoe_n_d;
        strb_d  = (mst_d != HBASP_M_STRB);
    end

    // Register master state and every pin output
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mst_q   <= HBASP_M_IDLE;
            addr_q  <= `HBASP_ADDR_RST;
            tc_q    <= `HBASP_TC_RST;
            siz_q   <= `HBASP_SIZ_RST;
            rw_q    <= 1'b1;
            aoe_n_q <= 1'b1;
            strb_q  <= 1'b1;
            soe_n_q <= 1'b1;
        end
        else
        begin
            mst_q   <= mst_d;
            addr_q  <= addr_d;
            tc_q    <= tc_d;
            siz_q   <= siz_d;
            rw_q    <= rw_d;
            aoe_n_q <= aoe_n_d;
            strb_q  <= strb_d;
            soe_n_q <= soe_n_d;
        end
    end

    assign addr_out                 = addr_q;
    assign addr_oe_n                = aoe_n_q;
    assign transfer_code_out        = tc_q;
    assign byte_count_code_out      = siz_q;
    assign rw_out                   = rw_q;
    assign cycle_valid_strobe_n_out = strb_q;
    assign cycle_valid_strobe_oe_n  = soe_n_q;
    assign mst_busy                 = (mst_q != HBASP_M_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Slave tracker

    hbasp_slv_t  slv_q, slv_d;
    hbasp_addr_t saddr_q, saddr_d;
    logic        sreg_q, sreg_d;
    logic        swin_q, swin_d;
    logic        claim_q, claim_d;
    logic        end_q, end_d;
    logic        slv_ok;

    // Own strobe shows on the input too; ignore it only while we drive the pin
    assign slv_ok   = soe_n_q;
    assign slv_idle = (slv_q == HBASP_S_IDLE);

    // Decisions only at falling edges; setup is met there, not at the strobe edge
    always_comb
    begin
        slv_d   = slv_q;
        saddr_d = saddr_q;
        sreg_d  = sreg_q;
        swin_d  = swin_q;
        claim_d = 1'b0;
        end_d   = 1'b0;
        if (hclk_fall && slv_ok)
        begin
            unique case (slv_q)
                HBASP_S_IDLE:
                begin
                    if (!strb_s)
                    begin
                        saddr_d = addr_s;
                        sreg_d  = ~regsel_s;
                        swin_d  = ~winsel_s & regsel_s;
                        if (!regsel_s || !winsel_s)
                        begin
                            slv_d   = HBASP_S_ACTIVE;
                            claim_d = 1'b1;
                        end
                        else
                            slv_d = HBASP_S_IGNORE;
                    end
                end
                HBASP_S_ACTIVE:
                begin
                    if (strb_s)
                    begin
                        slv_d = HBASP_S_IDLE;
                        end_d = 1'b1;
                    end
                end
                HBASP_S_IGNORE:
                begin
                    if (strb_s)
                        slv_d = HBASP_S_IDLE;
                end
            endcase
        end
    end

    // Register slave state and results
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            slv_q   <= HBASP_S_IDLE;
            saddr_q <= `HBASP_ADDR_RST;
            sreg_q  <= 1'b0;
            swin_q  <= 1'b0;
            claim_q <= 1'b0;
            end_q   <= 1'b0;
        end
        else
        begin
            slv_q   <= slv_d;
            saddr_q <= saddr_d;
            sreg_q  <= sreg_d;
            swin_q  <= swin_d;
            claim_q <= claim_d;
            end_q   <= end_d;
        end
    end

    assign slv_claim     = claim_q;
    assign slv_end       = end_q;
    assign slv_active    = (slv_q == HBASP_S_ACTIVE);
    assign slv_addr      = saddr_q;
    // upper address bits ignored for offset
    assign slv_offset    = saddr_q[`HBASP_OFF_W-1:0];
    assign slv_to_regs   = sreg_q;
    assign slv_to_window = swin_q;

endmodule // hbasp_port

// [include/hbasp_map.svh]
// Constants for the host bus address strobe port: widths, field positions, reset values
`ifndef HBASP_MAP_SVH
`define HBASP_MAP_SVH

`define HBASP_ADDR_W        32
`define HBASP_TC_W          4
`define HBASP_SIZ_W         2
`define HBASP_OFF_W         12
`define HBASP_SYNC_W        36
`define HBASP_SYNC_CLK      0
`define HBASP_SYNC_STRB     1
`define HBASP_SYNC_REGSEL   2
`define HBASP_SYNC_WINSEL   3
`define HBASP_SYNC_ADDR_LO  4
`define HBASP_SYNC_ADDR_HI  35
`define HBASP_ADDR_RST      32'h0000_0000
`define HBASP_TC_RST        4'h0
`define HBASP_SIZ_RST       2'h0
`define HBASP_OFF_RST       12'h000

`endif

// [include/hbasp_pkg.sv]
// Types shared by the host bus address strobe port
package hbasp_pkg;
`include "hbasp_map.svh"

    typedef logic [`HBASP_ADDR_W-1:0] hbasp_addr_t;
    typedef logic [`HBASP_TC_W-1:0]   hbasp_tc_t;
    typedef logic [`HBASP_SIZ_W-1:0]  hbasp_siz_t;
    typedef logic [`HBASP_OFF_W-1:0]  hbasp_off_t;

    // Master side sequencer, one-hot
    typedef enum logic [4:0] {
        HBASP_M_IDLE  = 5'b00001,
        HBASP_M_WRISE = 5'b00010,
        HBASP_M_ADDR  = 5'b00100,
        HBASP_M_STRB  = 5'b01000,
        HBASP_M_NEG   = 5'b10000
    } hbasp_mst_t;

    // Slave side tracker, one-hot
    typedef enum logic [2:0] {
        HBASP_S_IDLE   = 3'b001,
        HBASP_S_ACTIVE = 3'b010,
        HBASP_S_IGNORE = 3'b100
    } hbasp_slv_t;
endpackage

// [verif/hbasp_asserts.sv]
// Checker for the host bus address strobe port
`timescale 1ns/1ps
module hbasp_asserts
(
    input wire logic                   clk,
    input wire logic                   srst,
    input wire hbasp_pkg::hbasp_addr_t addr_out,
    input wire logic                   addr_oe_n,
    input wire hbasp_pkg::hbasp_tc_t   transfer_code_out,
    input wire logic                   cycle_valid_strobe_n_out,
    input wire logic                   cycle_valid_strobe_oe_n,
    input wire logic                   mst_busy,
    input wire logic                   mst_done,
    input wire logic                   slv_claim,
    input wire logic                   slv_active,
    input wire hbasp_pkg::hbasp_addr_t slv_addr,
    input wire hbasp_pkg::hbasp_off_t  slv_offset,
    input wire logic                   slv_to_regs,
    input wire logic                   slv_to_window
);
    import hbasp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // owner drives address
    property p_own; !addr_oe_n |-> mst_busy; endproperty
    a_own: assert property (p_own) else $error("address driven while idle");
    property p_oe; cycle_valid_strobe_oe_n == addr_oe_n && (cycle_valid_strobe_n_out || !addr_oe_n); endproperty
    a_oe: assert property (p_oe) else $error("strobe enable wrong");
    property p_rel; $rose(cycle_valid_strobe_oe_n) |-> $past(cycle_valid_strobe_n_out); endproperty
    a_rel: assert property (p_rel) else $error("strobe released while low");
    property p_after; $fell(cycle_valid_strobe_n_out) |-> !$past(addr_oe_n, 2); endproperty
    a_after: assert property (p_after) else $error("strobe too soon after address");
    property p_hold; !cycle_valid_strobe_n_out |-> $stable(addr_out) && $stable(transfer_code_out); endproperty
    a_hold: assert property (p_hold) else $error("address moved under strobe");
    property p_keep; !cycle_valid_strobe_n_out && !mst_done |=> !cycle_valid_strobe_n_out; endproperty
    a_keep: assert property (p_keep) else $error("strobe dropped early");
    property p_done; !cycle_valid_strobe_n_out && mst_done |=> cycle_valid_strobe_n_out && !cycle_valid_strobe_oe_n;
    endproperty
    a_done: assert property (p_done) else $error("strobe not driven high at end");
    property p_claim; slv_claim |-> (slv_to_regs ^ slv_to_window) && slv_active && addr_oe_n; endproperty
    a_claim: assert property (p_claim) else $error("bad claim");
    property p_off; slv_active |-> slv_offset == slv_addr[11:0] && (slv_claim || $stable(slv_addr)); endproperty
    a_off: assert property (p_off) else $error("offset mismatch");
endmodule // hbasp_asserts

// [verif/hbasp_host_model.sv]
// External host bus master model with a free running bus clock
`timescale 1ns/1ps
module hbasp_host_model
(
    input  wire logic              clk,
    output logic                   host_bus_clock,
    output hbasp_pkg::hbasp_addr_t h_addr,
    output logic                   h_strb_n,
    output logic                   register_select_n,
    output logic                   bridge_window_select_n
);
    import hbasp_pkg::*;
    logic [2:0] cnt;
    initial
    begin
        host_bus_clock = 0;
        cnt = 0;
        h_addr = 32'h0000_0000;
        h_strb_n = 1;
        register_select_n = 1;
        bridge_window_select_n = 1;
    end
    ////////////////////////////////////////
    // Bus clock, six clk per half period so sync lag fits
    always @(posedge clk)
    begin
        cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
        if (cnt == 3'h5)
            host_bus_clock <= ~host_bus_clock;
    end
    // One transaction; released address lines show the inverse value
    task automatic cycle(input hbasp_addr_t a, input logic rs, input logic ws);
        @(negedge host_bus_clock);
        @(posedge clk);
        h_strb_n <= 0;
        // qualifiers follow the strobe one clock late
        @(posedge clk);
        h_addr <= a;
        register_select_n <= rs;
        bridge_window_select_n <= ws;
        repeat (2) @(posedge host_bus_clock);
        @(posedge clk);
        h_strb_n <= 1;
        register_select_n <= 1;
        bridge_window_select_n <= 1;
        h_addr <= ~a;
        repeat (2) @(posedge host_bus_clock);
    endtask
endmodule // hbasp_host_model

// [verif/hbasp_port_test.sv]
// Self-checking bench for the host bus address strobe port
`timescale 1ns/1ps
module hbasp_port_test;
    import hbasp_pkg::*;
    logic        clk = 0, srst = 1, bus_owned = 0, mst_req = 0, mst_rw = 0, mst_done = 0;
    hbasp_addr_t mst_addr = 32'h0000_0000, h_addr, addr_out, slv_addr, addr_wire;
    hbasp_tc_t   mst_tc = 4'h0, transfer_code_out;
    hbasp_siz_t  mst_siz = 2'h0, byte_count_code_out;
    hbasp_off_t  slv_offset;
    logic        host_bus_clock, h_strb_n, register_select_n, bridge_window_select_n, strb_wire, rw_out;
    logic        addr_oe_n, cycle_valid_strobe_n_out, cycle_valid_strobe_oe_n, mst_busy;
    logic        slv_claim, slv_end, slv_active, slv_to_regs, slv_to_window;
    int          miscompares = 0, n_compared = 0, n_claims = 0, n_ends = 0, n_act = 0;
    ////////////////////////////////////////
    // Wire levels resolved from both drivers
    assign addr_wire = addr_oe_n ? h_addr : addr_out;
    assign strb_wire = cycle_valid_strobe_oe_n ? h_strb_n : cycle_valid_strobe_n_out;
    always #2.5 clk = ~clk;
    hbasp_port hbasp_port_i (.clk, .srst, .host_bus_clock, .addr_in(addr_wire), .addr_out, .addr_oe_n,
        .transfer_code_out, .byte_count_code_out, .rw_out, .cycle_valid_strobe_n_in(strb_wire),
        .cycle_valid_strobe_n_out, .cycle_valid_strobe_oe_n, .register_select_n, .bridge_window_select_n,
        .bus_owned, .mst_req, .mst_addr, .mst_tc, .mst_siz, .mst_rw, .mst_done, .mst_busy, .slv_claim,
        .slv_end, .slv_active, .slv_addr, .slv_offset, .slv_to_regs, .slv_to_window);
    hbasp_host_model hbasp_host_model_i (.clk, .host_bus_clock, .h_addr, .h_strb_n, .register_select_n,
        .bridge_window_select_n);
    // Claim and end pulses and active cycles counted
    always @(posedge clk)
    begin
        if (slv_claim === 1'b1)
            n_claims <= n_claims + 1;
        if (slv_end === 1'b1)
            n_ends <= n_ends + 1;
        if (slv_active === 1'b1)
            n_act <= n_act + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("Compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////
    // Master cycle, bus ownership granted late
    task automatic t_master(input hbasp_addr_t a, input hbasp_tc_t tc, input hbasp_siz_t sz, input logic rw);
        int n;
        @(posedge clk);
        mst_req <= 1;
        mst_addr <= a;
        mst_tc <= tc;
        mst_siz <= sz;
        mst_rw <= rw;
        @(posedge clk);
        mst_req <= 0;
        repeat (24) tick;
        check("oe_unowned", addr_oe_n, 1);
        @(posedge clk);
        bus_owned <= 1;
        for (n = 0; n < 100 && addr_oe_n !== 1'b0; n++) tick;
        check("addr", addr_wire, a);
        check("code", {transfer_code_out, byte_count_code_out, rw_out}, {tc, sz, rw});
        check("strobe_pre", cycle_valid_strobe_n_out, 1);
        for (n = 0; n < 100 && cycle_valid_strobe_n_out !== 1'b0; n++) tick;
        check("clk_at_strobe", {cycle_valid_strobe_n_out, host_bus_clock}, 0);
        repeat (20) tick;
        check("strobe_held", strb_wire, 0);
        @(posedge clk);
        mst_done <= 1;
        @(posedge clk);
        mst_done <= 0;
        tick;
        check("negated", {cycle_valid_strobe_oe_n, strb_wire}, 2'h1);
        for (n = 0; n < 100 && addr_oe_n !== 1'b1; n++) tick;
        check("end", {addr_oe_n, strb_wire, mst_busy}, 32'h0000_0006);
        @(posedge clk);
        bus_owned <= 0;
    endtask
    // Incoming cycle, claim judged from the selects
    task automatic t_slave(input hbasp_addr_t a, input logic rs, input logic ws);
        int c0;
        int e0;
        int a0;
        c0 = n_claims;
        e0 = n_ends;
        a0 = n_act;
        hbasp_host_model_i.cycle(a, rs, ws);
        check("claims", 32'(n_claims - c0), {31'h0, !(rs & ws)});
        check("ends", 32'(n_ends - e0), {31'h0, !(rs & ws)});
        // Active from the claiming fall to the next fall: one host period of 12 clk
        check("active_cycles", 32'(n_act - a0), (rs & ws) ? 32'h0000_0000 : 32'h0000_000C);
        if (!(rs & ws))
        begin
            check("slv_addr", slv_addr, a);
            check("offset", slv_offset, a[11:0]);
            check("target", {slv_to_regs, slv_to_window, slv_active}, {!rs, rs & !ws, 1'b0});
        end
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 0;
        tick;
        check("reset", {cycle_valid_strobe_oe_n, addr_oe_n, cycle_valid_strobe_n_out, mst_busy}, 4'hE);
        repeat (8) tick;
        t_master(32'hA5C3_0F18, 4'h9, 2'h2, 1'b0);
        t_master(32'h5A3C_F0E7, 4'h6, 2'h1, 1'b1);
        t_slave(32'hFEDC_B123, 1'b0, 1'b1);
        t_slave(32'h1234_5ABC, 1'b1, 1'b0);
        t_slave(32'h0F0F_0FFF, 1'b0, 1'b0);
        t_slave(32'h8000_0001, 1'b1, 1'b1);
        t_master(32'hFFFF_F000, 4'hF, 2'h3, 1'b1);
        finish_test;
    end
    // Watchdog far beyond the expected run
    initial
    begin
        #100000;
        miscompares++;
        finish_test;
    end
endmodule // hbasp_port_test
bind hbasp_port hbasp_asserts hbasp_asserts_i (.clk, .srst, .addr_out, .addr_oe_n, .transfer_code_out,
    .cycle_valid_strobe_n_out, .cycle_valid_strobe_oe_n, .mst_busy, .mst_done, .slv_claim, .slv_active,
    .slv_addr, .slv_offset, .slv_to_regs, .slv_to_window);
